// ### src/dpllc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DPLLC_DEFS_SVH
`define DPLLC_DEFS_SVH
`define DPLLC_CLK_NS 100
`define DPLLC_FP8K_NS 125000
`define DPLLC_FP8K_CYC (`DPLLC_FP8K_NS / `DPLLC_CLK_NS)
`define DPLLC_FP2K_NS 500000
`define DPLLC_FP2K_CYC (`DPLLC_FP2K_NS / `DPLLC_CLK_NS)
`define DPLLC_SYNC_MIN_NS 5
`define DPLLC_SYNC_MIN_CYC (((`DPLLC_SYNC_MIN_NS + `DPLLC_CLK_NS - 1) / `DPLLC_CLK_NS) < 1 ? 1 : \
  ((`DPLLC_SYNC_MIN_NS + `DPLLC_CLK_NS - 1) / `DPLLC_CLK_NS))
`define DPLLC_RST_MIN_NS 300
`define DPLLC_ACT_WIN_CYC 64
`define DPLLC_LOCK_CYC 8192
`define DPLLC_OFS_CTRL 8'h00
`define DPLLC_OFS_STATUS 8'h04
`define DPLLC_OFS_SDH_FREQ 8'h08
`define DPLLC_OFS_PROG_FREQ 8'h0c
`define DPLLC_OFS_DIFF_FREQ 8'h10
`define DPLLC_OFS_FP_STYLE 8'h14
`define DPLLC_OFS_INT_STAT 8'h18
`define DPLLC_OFS_INT_MASK 8'h1c
`define DPLLC_CTRL_AUTO 0
`define DPLLC_CTRL_MREF_LO 1
`define DPLLC_CTRL_MREF_HI 2
`define DPLLC_CTRL_MODE 3
`define DPLLC_CTRL_DIFF_EN 4
`define DPLLC_CTRL_RST 5'h01
`define DPLLC_PROG_2K_BIT 15
`define DPLLC_PROG_MULT_MAX 14'h25f8
`define DPLLC_PROG_FREQ_RST 16'h0100
`define DPLLC_FP_STYLE_RST 4'h0
`define DPLLC_INT_MASK_RST 4'h0
`define DPLLC_INT_LOCK 0
`define DPLLC_INT_HOLD 1
`define DPLLC_INT_REFSW 2
`define DPLLC_INT_LOSS 3
`endif

// ### src/dpllc_pkg.sv
// types shared by the pin-level control block
package dpllc_pkg;
  typedef enum logic [2:0] {
    DPLLC_SDH_6M48 = 3'h0,
    DPLLC_SDH_19M44 = 3'h1,
    DPLLC_SDH_25M92 = 3'h2,
    DPLLC_SDH_38M88 = 3'h3,
    DPLLC_SDH_51M84 = 3'h4,
    DPLLC_SDH_77M76 = 3'h5
  } dpllc_sdh_freq_e;
  typedef enum logic [2:0] {
    DPLLC_DIFF_19M44 = 3'h0,
    DPLLC_DIFF_38M88 = 3'h1,
    DPLLC_DIFF_77M76 = 3'h2,
    DPLLC_DIFF_155M52 = 3'h3,
    DPLLC_DIFF_311M04 = 3'h4,
    DPLLC_DIFF_622M08 = 3'h5
  } dpllc_diff_freq_e;
  typedef enum logic [1:0] {
    DPLLC_ST_FREERUN = 2'b00,
    DPLLC_ST_ACQUIRE = 2'b01,
    DPLLC_ST_LOCKED = 2'b10,
    DPLLC_ST_HOLDOVER = 2'b11
  } dpllc_state_e;
  typedef logic [1:0] dpllc_ref_t;
endpackage

// ### src/dpllc_pin_ctrl.sv
// pin-level control: reference selection, output generators, mode, diff enable, interrupt
// Operation
// - any of the three timing inputs is the source, chosen automatically or by a software register.
// - each frame align input pairs with its same-numbered timing input and takes a 50% clock or a pulse of 5 ns or more.
// - the telecom line clock is set to any SONET/SDH rate up to 77.76 MHz and starts at 77.76 MHz.
// - the telecom frame pulse has a settable style, follows the telecom line clock and starts at 8 kHz.
// - the programmable clock takes any multiple of 8 kHz up to 77.76 MHz or 2 kHz and starts at 2.048 MHz.
// - the programmable frame pulse has a settable style, follows the programmable clock and starts at 8 kHz.
// - the differential clock takes any SDH rate and starts at 622.08 MHz.
// - the block is held in reset while the reset input is asserted.
// - the mode strap level present at reset sets the default mode, Normal or Freerun.
// - after reset the mode follows changes of the strap pin or writes to the mode register.
// - the differential driver is on while its enable pin is high and tristated while low.
// - a software bit can also enable or disable the differential driver; here the driver is on only while both the pin and the bit are high.
// - the lock output is high once the loop is locked to the selected reference.
// - the holdover output is high while the loop is in holdover.
// - the open-drain active-low interrupt signals a change of status.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "dpllc_defs.svh"
module dpllc_pin_ctrl #(
  parameter int FP2K_CYC = `DPLLC_FP2K_CYC,
  parameter int LOCK_CYC = `DPLLC_LOCK_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMING_INPUT_ZERO,
  input wire logic TIMING_INPUT_ONE,
  input wire logic TIMING_INPUT_TWO,
  input wire logic FRAME_ALIGN_INPUT_ZERO,
  input wire logic FRAME_ALIGN_INPUT_ONE,
  input wire logic FRAME_ALIGN_INPUT_TWO,
  input wire logic MODE_STRAP,
  input wire logic DIFF_ENABLE,
  output dpllc_pkg::dpllc_ref_t SELECTED_REF,
  output dpllc_pkg::dpllc_sdh_freq_e TELECOM_CLK_FREQ,
  output logic TELECOM_FRAME_PULSE_OUT,
  output logic [15:0] PROG_CLK_FREQ,
  output logic PROGRAMMABLE_FRAME_PULSE_OUT,
  output dpllc_pkg::dpllc_diff_freq_e DIFF_CLK_FREQ,
  output logic DIFF_DRIVE_OE_N,
  output logic FREERUN_MODE,
  output logic LOCK_OUT,
  output logic HOLDOVER_OUT,
  output logic INT_N_O,
  output logic INT_N_OE_N
);
  import dpllc_pkg::*;

  logic [2:0] ref_in;
  logic [2:0] ref_prev;
  logic [2:0] sync_in;
  logic [2:0] sync_prev;
  logic [2:0] ref_active;
  logic [2:0] ref_active_prev;
  logic [6:0] act_cnt [3];
  logic auto_sel;
  dpllc_ref_t manual_ref;
  logic mode_freerun;
  logic diff_sw_en;
  logic strap_pending;
  logic strap_prev;
  dpllc_ref_t sel_ref;
  dpllc_ref_t next_sel_ref;
  dpllc_state_e state;
  dpllc_state_e next_state;
  logic [13:0] lock_cnt;
  logic [12:0] tfp_cnt;
  logic [12:0] pfp_cnt;
  logic [12:0] pfp_period;
  logic [3:0] fp_style;
  logic [3:0] int_stat;
  logic [3:0] int_mask;
  logic [3:0] int_event;
  logic sel_sync_edge;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;

  // lowest-numbered active reference, or keep current one
  function automatic dpllc_ref_t first_active(input logic [2:0] act, input dpllc_ref_t cur);
    return act[0] ? 2'h0 : (act[1] ? 2'h1 : (act[2] ? 2'h2 : cur));
  endfunction

  // pulse level from counter and style: bit0 inverts, bit1 widens to two cycles
  function automatic logic fp_level(input logic [12:0] cnt, input logic [1:0] style);
    return (style[1] ? (cnt < 13'h0002) : (cnt == 13'h0000)) ^ style[0];
  endfunction
  function automatic logic addr_known(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `DPLLC_OFS_INT_MASK);
  endfunction
  assign ref_in = {TIMING_INPUT_TWO, TIMING_INPUT_ONE, TIMING_INPUT_ZERO};
  assign sync_in = {FRAME_ALIGN_INPUT_TWO, FRAME_ALIGN_INPUT_ONE, FRAME_ALIGN_INPUT_ZERO};
  assign addr_ok = addr_known(PADDR);
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // input history for edge detection
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ref_prev <= 3'h0;
      sync_prev <= 3'h0;
      ref_active_prev <= 3'h0;
    end else begin
      ref_prev <= ref_in;
      sync_prev <= sync_in;
      ref_active_prev <= ref_active;
    end
  end

  // activity monitor per reference: any edge within the window keeps it active
  for (genvar i = 0; i < 3; i++) begin : g_act
    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
        act_cnt[i] <= 7'h00;
        ref_active[i] <= 1'b0;
      end else if (ref_in[i] != ref_prev[i]) begin
        act_cnt[i] <= 7'(`DPLLC_ACT_WIN_CYC);
        ref_active[i] <= 1'b1;
      end else if (act_cnt[i] != 7'h00) begin
        act_cnt[i] <= act_cnt[i] - 7'h01;
      end else begin
        ref_active[i] <= 1'b0;
      end
    end
  end

  // sync of the selected reference realigns the frame pulses; a pulse of one sample suffices
  assign sel_sync_edge = sync_in[sel_ref] && !sync_prev[sel_ref];

  // reference selection
  always_comb begin
    next_sel_ref = sel_ref;
    if (!auto_sel) begin
      next_sel_ref = manual_ref;
    end else if (!ref_active[sel_ref]) begin
      next_sel_ref = first_active(ref_active, sel_ref);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sel_ref <= 2'h0;
    end else if (next_sel_ref != 2'h3) begin
      sel_ref <= next_sel_ref;
    end
  end

  // mode: strap caught at first edge after release, then pin changes or register writes
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      strap_pending <= 1'b1;
      strap_prev <= 1'b0;
      mode_freerun <= 1'b0;
    end else begin
      strap_prev <= MODE_STRAP;
      if (strap_pending) begin
        strap_pending <= 1'b0;
        mode_freerun <= !MODE_STRAP;
      end else if (MODE_STRAP != strap_prev) begin
        mode_freerun <= !MODE_STRAP;
      end else if (wr_en && PADDR == `DPLLC_OFS_CTRL) begin
        mode_freerun <= PWDATA[`DPLLC_CTRL_MODE];
      end
    end
  end

  // loop state
  always_comb begin
    next_state = state;
    case (state)
      DPLLC_ST_FREERUN: begin
        if (!mode_freerun) begin
          next_state = DPLLC_ST_ACQUIRE;
        end
      end
      DPLLC_ST_ACQUIRE: begin
        if (mode_freerun) begin
          next_state = DPLLC_ST_FREERUN;
        end else if (lock_cnt == 14'(LOCK_CYC - 1)) begin
          next_state = DPLLC_ST_LOCKED;
        end
      end
      DPLLC_ST_LOCKED: begin
        if (mode_freerun) begin
          next_state = DPLLC_ST_FREERUN;
        end else if (!ref_active[sel_ref]) begin
          next_state = DPLLC_ST_HOLDOVER;
        end else if (next_sel_ref != sel_ref) begin
          next_state = DPLLC_ST_ACQUIRE;
        end
      end
      DPLLC_ST_HOLDOVER: begin
        if (mode_freerun) begin
          next_state = DPLLC_ST_FREERUN;
        end else if (ref_active[sel_ref]) begin
          next_state = DPLLC_ST_ACQUIRE;
        end
      end
      default: begin
        next_state = DPLLC_ST_FREERUN;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= DPLLC_ST_FREERUN;
    end else begin
      state <= next_state;
    end
  end

  // acquisition timer, cleared on reference loss or change
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      lock_cnt <= 14'h0000;
    end else if (state != DPLLC_ST_ACQUIRE || !ref_active[sel_ref] || next_sel_ref != sel_ref) begin
      lock_cnt <= 14'h0000;
    end else if (lock_cnt != 14'(LOCK_CYC - 1)) begin
      lock_cnt <= lock_cnt + 14'h0001;
    end
  end

  // status pins
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      LOCK_OUT <= 1'b0;
      HOLDOVER_OUT <= 1'b0;
      SELECTED_REF <= 2'h0;
      FREERUN_MODE <= 1'b0;
    end else begin
      LOCK_OUT <= next_state == DPLLC_ST_LOCKED;
      HOLDOVER_OUT <= next_state == DPLLC_ST_HOLDOVER;
      SELECTED_REF <= sel_ref;
      FREERUN_MODE <= mode_freerun;
    end
  end

  // control register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      auto_sel <= 1'b1;
      manual_ref <= 2'h0;
      diff_sw_en <= 1'b1;
    end else if (wr_en && PADDR == `DPLLC_OFS_CTRL) begin
      auto_sel <= PWDATA[`DPLLC_CTRL_AUTO];
      manual_ref <= PWDATA[`DPLLC_CTRL_MREF_HI:`DPLLC_CTRL_MREF_LO];
      diff_sw_en <= PWDATA[`DPLLC_CTRL_DIFF_EN];
    end
  end

  // frequency and style settings, defaults on reset
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      TELECOM_CLK_FREQ <= DPLLC_SDH_77M76;
      PROG_CLK_FREQ <= `DPLLC_PROG_FREQ_RST;
      DIFF_CLK_FREQ <= DPLLC_DIFF_622M08;
      fp_style <= `DPLLC_FP_STYLE_RST;
    end else if (wr_en) begin
      if (PADDR == `DPLLC_OFS_SDH_FREQ && PWDATA[2:0] <= 3'(DPLLC_SDH_77M76)) begin
        TELECOM_CLK_FREQ <= dpllc_sdh_freq_e'(PWDATA[2:0]);
      end
      if (PADDR == `DPLLC_OFS_PROG_FREQ && (PWDATA[`DPLLC_PROG_2K_BIT] ||
          (PWDATA[13:0] != 14'h0000 && PWDATA[13:0] <= `DPLLC_PROG_MULT_MAX))) begin
        PROG_CLK_FREQ <= {PWDATA[15], 1'b0, PWDATA[13:0]};
      end
      if (PADDR == `DPLLC_OFS_DIFF_FREQ && PWDATA[2:0] <= 3'(DPLLC_DIFF_622M08)) begin
        DIFF_CLK_FREQ <= dpllc_diff_freq_e'(PWDATA[2:0]);
      end
      if (PADDR == `DPLLC_OFS_FP_STYLE) begin
        fp_style <= PWDATA[3:0];
      end
    end
  end

  // programmable frame pulse period follows its clock: 2 kHz clock gives 2 kHz pulse
  assign pfp_period = PROG_CLK_FREQ[`DPLLC_PROG_2K_BIT] ? 13'(FP2K_CYC) : 13'(`DPLLC_FP8K_CYC);
  // frame pulse counters, realigned by the selected sync input
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tfp_cnt <= 13'h0000;
      pfp_cnt <= 13'h0000;
    end else if (sel_sync_edge) begin
      tfp_cnt <= 13'h0000;
      pfp_cnt <= 13'h0000;
    end else begin
      tfp_cnt <= (tfp_cnt >= 13'(`DPLLC_FP8K_CYC - 1)) ? 13'h0000 : tfp_cnt + 13'h0001;
      pfp_cnt <= (pfp_cnt >= pfp_period - 13'h0001) ? 13'h0000 : pfp_cnt + 13'h0001;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      TELECOM_FRAME_PULSE_OUT <= 1'b0;
      PROGRAMMABLE_FRAME_PULSE_OUT <= 1'b0;
    end else begin
      TELECOM_FRAME_PULSE_OUT <= fp_level(tfp_cnt, fp_style[1:0]);
      PROGRAMMABLE_FRAME_PULSE_OUT <= fp_level(pfp_cnt, fp_style[3:2]);
    end
  end

  // differential driver: pin and software bit both must enable it
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      DIFF_DRIVE_OE_N <= 1'b1;
    end else begin
      DIFF_DRIVE_OE_N <= !(DIFF_ENABLE && diff_sw_en);
    end
  end

  // status events
  assign int_event[`DPLLC_INT_LOCK] = (next_state == DPLLC_ST_LOCKED) != (state == DPLLC_ST_LOCKED);
  assign int_event[`DPLLC_INT_HOLD] = (next_state == DPLLC_ST_HOLDOVER) != (state == DPLLC_ST_HOLDOVER);
  assign int_event[`DPLLC_INT_REFSW] = next_sel_ref != sel_ref && next_sel_ref != 2'h3;
  assign int_event[`DPLLC_INT_LOSS] = |(ref_active_prev & ~ref_active);

  // sticky status, write one to clear, set wins
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      int_stat <= 4'h0;
    end else if (wr_en && PADDR == `DPLLC_OFS_INT_STAT) begin
      int_stat <= (int_stat & ~PWDATA[3:0]) | int_event;
    end else begin
      int_stat <= int_stat | int_event;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      int_mask <= `DPLLC_INT_MASK_RST;
    end else if (wr_en && PADDR == `DPLLC_OFS_INT_MASK) begin
      int_mask <= PWDATA[3:0];
    end
  end

  // open-drain interrupt: only ever pulls low
  assign INT_N_O = 1'b0;
  assign INT_N_OE_N = !(|(int_stat & int_mask));

  // read data captured in the setup cycle
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (PADDR)
        `DPLLC_OFS_CTRL: PRDATA <= {27'h0, diff_sw_en, mode_freerun, manual_ref, auto_sel};
        `DPLLC_OFS_STATUS: PRDATA <= {24'h0, ref_active, mode_freerun, HOLDOVER_OUT, LOCK_OUT, sel_ref};
        `DPLLC_OFS_SDH_FREQ: PRDATA <= {29'h0, TELECOM_CLK_FREQ};
        `DPLLC_OFS_PROG_FREQ: PRDATA <= {16'h0, PROG_CLK_FREQ};
        `DPLLC_OFS_DIFF_FREQ: PRDATA <= {29'h0, DIFF_CLK_FREQ};
        `DPLLC_OFS_FP_STYLE: PRDATA <= {28'h0, fp_style};
        `DPLLC_OFS_INT_STAT: PRDATA <= {28'h0, int_stat};
        `DPLLC_OFS_INT_MASK: PRDATA <= {28'h0, int_mask};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### sim/dpllc_ref_src.sv
// reference clock and frame align sources
`timescale 1ns/10ps
module dpllc_ref_src (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] run,
  output logic [2:0] ref_clk,
  output logic [2:0] sync_p
);
  logic [10:0] cnt;
  // running refs toggle each cycle, stopped refs sit at the pull-down level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_clk <= 3'h0;
    end else begin
      ref_clk <= run & ~ref_clk;
    end
  end
  // one-cycle frame pulse every 1250 cycles, wider than the minimum
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 11'h0;
      sync_p <= 3'h0;
    end else begin
      cnt <= (cnt == 11'h4e1) ? 11'h0 : cnt + 11'h1;
      sync_p <= (cnt == 11'h0) ? run : 3'h0;
    end
  end
endmodule

// ### sim/dpllc_pin_ctrl_asserts.sv
// port checks for the pin-level control block
`timescale 1ns/10ps
module dpllc_pin_ctrl_asserts
  import dpllc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic MODE_STRAP,
  input wire logic DIFF_ENABLE,
  input dpllc_pkg::dpllc_sdh_freq_e TELECOM_CLK_FREQ,
  input wire logic [15:0] PROG_CLK_FREQ,
  input dpllc_pkg::dpllc_diff_freq_e DIFF_CLK_FREQ,
  input wire logic DIFF_DRIVE_OE_N,
  input wire logic FREERUN_MODE,
  input wire logic LOCK_OUT,
  input wire logic HOLDOVER_OUT
);
  logic acc;
  assign acc = PSEL && PENABLE;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  sequence ctl_wr_s;
    acc && PWRITE && PADDR == 8'h00;
  endsequence
  sequence rst_rel_s;
    $fell(RST);
  endsequence
  ready_tied_a: assert property (PREADY == acc) else $error("ready outside access");
  bad_addr_a: assert property (acc |-> PSLVERR == (PADDR > 8'h1c || PADDR[1:0] != 2'b00))
    else $error("error flag wrong");
  err_read_a: assert property (acc && !PWRITE && PSLVERR |-> PRDATA == 32'h0) else $error("refused read data");
  pin_off_a: assert property (!DIFF_ENABLE |=> DIFF_DRIVE_OE_N) else $error("driver on with pin low");
  sw_off_a: assert property (ctl_wr_s ##0 !PWDATA[4] |-> ##2 DIFF_DRIVE_OE_N)
    else $error("driver on with soft bit low");
  rst_defaults_a: assert property (rst_rel_s |-> TELECOM_CLK_FREQ == DPLLC_SDH_77M76 &&
    PROG_CLK_FREQ == 16'h0100 && DIFF_CLK_FREQ == DPLLC_DIFF_622M08 && !LOCK_OUT) else $error("reset defaults");
  strap_load_a: assert property (rst_rel_s |-> ##3 FREERUN_MODE == !$past(MODE_STRAP, 3))
    else $error("strap not loaded");
  strap_follow_a: assert property ($changed(MODE_STRAP) |-> ##3 FREERUN_MODE == !$past(MODE_STRAP, 3))
    else $error("strap not followed");
  lock_hold_a: assert property (!(LOCK_OUT && HOLDOVER_OUT)) else $error("lock and holdover");
endmodule
bind dpllc_pin_ctrl dpllc_pin_ctrl_asserts u_chk (
  .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MODE_STRAP(MODE_STRAP),
  .DIFF_ENABLE(DIFF_ENABLE), .TELECOM_CLK_FREQ(TELECOM_CLK_FREQ), .PROG_CLK_FREQ(PROG_CLK_FREQ),
  .DIFF_CLK_FREQ(DIFF_CLK_FREQ), .DIFF_DRIVE_OE_N(DIFF_DRIVE_OE_N), .FREERUN_MODE(FREERUN_MODE),
  .LOCK_OUT(LOCK_OUT), .HOLDOVER_OUT(HOLDOVER_OUT)
);

// ### sim/tb_top.sv
// self-checking bench for the pin-level control block
`timescale 1ns/10ps
`include "dpllc_defs.svh"
module tb_top;
  import dpllc_pkg::*;
  localparam int P2K = 200;
  localparam int LCK = 16;
  logic clock, rst, psel, penable, pwrite, strap, diff_en, pready, pslverr, e;
  logic tfp, pfp, oe_n, freerun, lock, hold, int_o, int_oe_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] run, ref_clk, sync_p;
  logic [15:0] prog_freq;
  dpllc_ref_t sel_ref;
  dpllc_sdh_freq_e tel_freq;
  dpllc_diff_freq_e diff_freq;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  dpllc_pin_ctrl #(.FP2K_CYC(P2K), .LOCK_CYC(LCK)) u_dut (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMING_INPUT_ZERO(ref_clk[0]), .TIMING_INPUT_ONE(ref_clk[1]), .TIMING_INPUT_TWO(ref_clk[2]),
    .FRAME_ALIGN_INPUT_ZERO(sync_p[0]), .FRAME_ALIGN_INPUT_ONE(sync_p[1]), .FRAME_ALIGN_INPUT_TWO(sync_p[2]),
    .MODE_STRAP(strap), .DIFF_ENABLE(diff_en), .SELECTED_REF(sel_ref), .TELECOM_CLK_FREQ(tel_freq),
    .TELECOM_FRAME_PULSE_OUT(tfp), .PROG_CLK_FREQ(prog_freq), .PROGRAMMABLE_FRAME_PULSE_OUT(pfp),
    .DIFF_CLK_FREQ(diff_freq), .DIFF_DRIVE_OE_N(oe_n), .FREERUN_MODE(freerun), .LOCK_OUT(lock),
    .HOLDOVER_OUT(hold), .INT_N_O(int_o), .INT_N_OE_N(int_oe_n)
  );
  dpllc_ref_src u_src (.clock(clock), .rst(rst), .run(run), .ref_clk(ref_clk), .sync_p(sync_p));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // cycles between the second and third rising edge of a frame pulse
  task automatic period(input logic p, input int x);
    int n, k;
    logic v, l;
    n = 0;
    k = -1;
    l = 1'b1;
    while (k < 2 && n < 9000) begin
      @(posedge clock);
      v = p ? pfp : tfp;
      n++;
      if (v === 1'b1 && l !== 1'b1) begin
        k++;
        if (k == 1) n = 0;
      end
      l = v;
    end
    chk(32'(n), 32'(x));
  endtask
  // length of the high run of a frame pulse
  task automatic width(input logic p, input int x);
    int n;
    n = 0;
    while ((p ? pfp : tfp) !== 1'b0 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    while ((p ? pfp : tfp) !== 1'b1 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while ((p ? pfp : tfp) === 1'b1 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n), 32'(x));
  endtask
  // cycles from the second selected sync pulse to the telecom frame pulse
  task automatic align(input int x);
    int n;
    n = 0;
    repeat (2) begin
      while (sync_p[0] !== 1'b0) begin
        @(posedge clock);
      end
      while (sync_p[0] !== 1'b1 && n < 9000) begin
        @(posedge clock);
        n++;
      end
    end
    n = 0;
    while (tfp !== 1'b1 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n), 32'(x));
  endtask
  task automatic do_reset(input logic s);
    rst <= 1'b1;
    strap <= s;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
  endtask
  initial begin
    {rst, strap, diff_en, psel, penable, pwrite, run} = 9'h1c0;
    paddr = 8'h0;
    pwdata = 32'h0;
    do_reset(1'b1);
    chk(32'(freerun), 32'h0);
    rd(`DPLLC_OFS_SDH_FREQ, 32'h5);
    rd(`DPLLC_OFS_PROG_FREQ, 32'h100);
    rd(`DPLLC_OFS_DIFF_FREQ, 32'h5);
    rd(`DPLLC_OFS_FP_STYLE, 32'h0);
    rd(8'h20, 32'h0);
    chk(32'(e), 32'h1);
    period(1'b0, 1250);
    period(1'b1, 1250);
    apb(1'b1, `DPLLC_OFS_FP_STYLE, 32'h6);
    rd(`DPLLC_OFS_FP_STYLE, 32'h6);
    width(1'b0, 2);
    width(1'b1, 1249);
    apb(1'b1, `DPLLC_OFS_FP_STYLE, 32'h0);
    apb(1'b1, `DPLLC_OFS_PROG_FREQ, 32'h8000);
    chk(32'(prog_freq), 32'h8000);
    period(1'b1, P2K);
    apb(1'b1, `DPLLC_OFS_PROG_FREQ, 32'h25f8);
    apb(1'b1, `DPLLC_OFS_PROG_FREQ, 32'h0);
    chk(32'(prog_freq), 32'h25f8);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, `DPLLC_OFS_SDH_FREQ, 32'(i));
      apb(1'b1, `DPLLC_OFS_DIFF_FREQ, 32'(i));
      chk(32'(tel_freq), 32'(i < 6 ? i : 5));
      chk(32'(diff_freq), 32'(i < 6 ? i : 5));
    end
    diff_en <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'(oe_n), 32'h1);
    diff_en <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(oe_n), 32'h0);
    apb(1'b1, `DPLLC_OFS_CTRL, 32'h01);
    chk(32'(oe_n), 32'h1);
    apb(1'b1, `DPLLC_OFS_CTRL, 32'h11);
    chk(32'(oe_n), 32'h0);
    strap <= 1'b0;
    repeat (5) @(posedge clock);
    chk(32'(freerun), 32'h1);
    apb(1'b1, `DPLLC_OFS_CTRL, 32'h11);
    chk(32'(freerun), 32'h0);
    apb(1'b1, `DPLLC_OFS_CTRL, 32'h19);
    chk(32'(freerun), 32'h1);
    apb(1'b1, `DPLLC_OFS_CTRL, 32'h11);
    run <= 3'h1;
    repeat (LCK + 20) @(posedge clock);
    chk(32'(lock), 32'h1);
    chk(32'(sel_ref), 32'h0);
    chk(32'(int_oe_n), 32'h1);
    apb(1'b1, `DPLLC_OFS_INT_MASK, 32'h1);
    chk(32'(int_oe_n), 32'h0);
    chk(32'(int_o), 32'h0);
    apb(1'b1, `DPLLC_OFS_INT_STAT, 32'h1);
    chk(32'(int_oe_n), 32'h1);
    align(2);
    run <= 3'h0;
    repeat (100) @(posedge clock);
    chk(32'(hold), 32'h1);
    chk(32'(lock), 32'h0);
    chk(32'(int_oe_n), 32'h0);
    run <= 3'h2;
    repeat (10) @(posedge clock);
    chk(32'(sel_ref), 32'h1);
    rd(`DPLLC_OFS_STATUS, 32'h41);
    rd(`DPLLC_OFS_INT_STAT, 32'hf);
    apb(1'b1, `DPLLC_OFS_CTRL, 32'h14);
    chk(32'(sel_ref), 32'h2);
    apb(1'b1, `DPLLC_OFS_CTRL, 32'h16);
    chk(32'(sel_ref), 32'h2);
    do_reset(1'b0);
    chk(32'(freerun), 32'h1);
    chk(32'(hold), 32'h0);
    chk(32'(tel_freq), 32'(DPLLC_SDH_77M76));
    chk(32'(prog_freq), 32'h100);
    chk(32'(diff_freq), 32'(DPLLC_DIFF_622M08));
    wrap_up();
  end
endmodule
